// [hw/pv_defs.vh]
// Constants for the profile velocity command block: object addresses, field positions, reset values.
// Included by the control decoding design file of this block only, not by the ramp.
`ifndef PV_DEFS_VH
`define PV_DEFS_VH
`define CW_ADDR 16'h6040
`define CW_RESET 16'h0000
`define CW_HALT_BIT 8
`define CW_FAULT_BIT 7
`define CW_TYPE_LO 12
`define CW_TYPE_HI 13
`define TYPE_POS 2'h0
`define TYPE_SPD 2'h1
`define TYPE_PUSH 2'h2
`define TYPE_TRQ 2'h3
`define HALT_SLOW 3'h1
`define HALT_QUICK 3'h2
`define HALT_QUICK_SHIFT 2
`define START_SPEED_RESET 32'h0000_1388
`define PUSH_DEV_STEPS 32'h0000_003C
`define DEV_LIMIT_RESET 32'h0000_0FA0
`define OVL_LIMIT_RESET 16'h00C8
`endif

// [hw/pv_ramp.v]
// Speed ramp: moves a signed command speed toward a goal by a fixed step per tick.
// Assumes step and goal come from logic on the same clock.
`timescale 1ns/1ps
module pv_ramp #(
    parameter W = 32
) (
    input wire mclk,
    input wire reset,
    input wire ce,
    input wire tick,
    input wire jump,
    input wire [W-1:0] goal,
    input wire [W-1:0] step,
    output reg [W-1:0] speed_q
);
    wire signed [W-1:0] g = goal;
    wire signed [W-1:0] s = speed_q;
    wire signed [W:0] diff = {g[W-1], g} - {s[W-1], s};
    wire signed [W:0] st = {1'b0, step};
    reg [W-1:0] speed_d;
    always @* begin
        speed_d = speed_q;
        if (jump)
            speed_d = goal;
        else if (tick) begin
            if (diff > st)
                speed_d = speed_q + step;
            else if (diff < -st)
                speed_d = speed_q - step;
            else
                speed_d = goal;
        end
    end
    always @(posedge mclk) begin
        if (reset)
            speed_q <= {W{1'b0}};
        else if (ce)
            speed_q <= speed_d;
    end
endmodule // pv_ramp

// [hw/pv_control.v]
// Profile velocity command decoding: control word, submode, halt, ramp and load alarms.
// Assumes the control word and object values arrive on mclk; feedback deviation from the loop.
`timescale 1ns/1ps
`include "pv_defs.vh"
module pv_control #(
    parameter W = 32,
    parameter [W-1:0] START_SPEED = `START_SPEED_RESET,
    parameter [W-1:0] DEV_LIMIT = `DEV_LIMIT_RESET,
    parameter [15:0] OVL_LIMIT = `OVL_LIMIT_RESET,
    parameter [W-1:0] PUSH_DEV = `PUSH_DEV_STEPS
) (
    input wire mclk,
    input wire reset,
    input wire ce,
    input wire cw_we,
    input wire [15:0] cw_addr,
    input wire [15:0] cw_wdata,
    output reg [15:0] cw_rdata,
    input wire [W-1:0] target_velocity,
    input wire [W-1:0] accel_step,
    input wire [W-1:0] decel_step,
    input wire [2:0] halt_option,
    input wire ramp_tick,
    input wire [W-1:0] position_deviation,
    input wire torque_at_limit,
    input wire load_contact,
    input wire feedback_at_target,
    output reg [W-1:0] command_speed,
    output reg direction_q,
    output reg [1:0] submode_q,
    output reg pressing_q,
    output reg [W-1:0] deviation_hold_q,
    output reg overload_alarm_q,
    output reg deviation_alarm_q,
    output reg target_reached_q,
    output reg speed_zero_q
);
    // Motion phases, one-hot; stop is the ramp down after go has dropped
    localparam [2:0] PH_IDLE = 3'h1;
    localparam [2:0] PH_RUN = 3'h2;
    localparam [2:0] PH_STOP = 3'h4;

    reg [15:0] cw_q;
    reg [2:0] phase_q;
    reg [2:0] phase_d;
    reg [15:0] ovl_cnt_q;
    wire [W-1:0] ramp_speed;
    wire cw_hit = (cw_addr == `CW_ADDR);
    wire cw_write = cw_we && cw_hit;
    wire fault_clear = cw_write && cw_wdata[`CW_FAULT_BIT];
    wire halt = cw_q[`CW_HALT_BIT];
    wire [1:0] sub = cw_q[`CW_TYPE_HI:`CW_TYPE_LO];
    wire tv_zero = (target_velocity == {W{1'b0}});
    wire tv_neg = target_velocity[W-1];
    wire ramp_zero = (ramp_speed == {W{1'b0}});
    wire pos_mode = (sub == `TYPE_POS);
    wire push_mode = (sub == `TYPE_PUSH) || (sub == `TYPE_TRQ);
    wire running = (phase_q != PH_IDLE);
    wire [W-1:0] dev_abs = position_deviation[W-1] ? (~position_deviation + 1'b1) : position_deviation;
    // Starting speed carries the target's sign so the ramp never crosses zero on start
    wire [W-1:0] start_signed = tv_neg ? (~START_SPEED + 1'b1) : START_SPEED;
    wire go = !halt && !tv_zero;
    wire quick = (halt_option == `HALT_QUICK);
    wire [W-1:0] goal = go ? target_velocity : {W{1'b0}};
    // Quick stop only steepens the slope; a large step can still land on zero in one tick
    wire [W-1:0] stop_step = quick ? (decel_step << `HALT_QUICK_SHIFT) : decel_step;
    wire [W-1:0] step = go ? accel_step : stop_step;
    // Start jumps to starting speed (ramped submodes) or directly to target (torque)
    wire start = go && !running;
    wire jump_start = start && (sub != `TYPE_TRQ);
    wire jump_trq = go && (sub == `TYPE_TRQ) && (ramp_speed != target_velocity);
    wire jump = jump_start || jump_trq;
    wire [W-1:0] jump_val = jump_trq ? target_velocity : start_signed;
    wire [W-1:0] ramp_goal = jump ? jump_val : goal;
    wire ovl_full = (ovl_cnt_q == OVL_LIMIT);
    wire ovl_set = !push_mode && ovl_full;
    wire dev_set = pos_mode && running && (dev_abs > DEV_LIMIT);

    pv_ramp #(.W(W)) u_ramp (
        .mclk(mclk),
        .reset(reset),
        .ce(ce),
        .tick(ramp_tick),
        .jump(jump),
        .goal(ramp_goal),
        .step(step),
        .speed_q(ramp_speed)
    );

    always @* begin
        phase_d = phase_q;
        case (phase_q)
            PH_IDLE: begin
                if (go)
                    phase_d = PH_RUN;
            end
            PH_RUN: begin
                if (!go)
                    phase_d = ramp_zero ? PH_IDLE : PH_STOP;
            end
            PH_STOP: begin
                if (go)
                    phase_d = PH_RUN;
                else if (ramp_zero)
                    phase_d = PH_IDLE;
            end
            default: phase_d = PH_IDLE;
        endcase
    end

    always @(posedge mclk) begin
        if (reset)
            phase_q <= PH_IDLE;
        else if (ce)
            phase_q <= phase_d;
    end

    // The submode field acts from the next edge, without waiting for a new start
    always @(posedge mclk) begin
        if (reset)
            cw_q <= `CW_RESET;
        else if (ce && cw_write)
            cw_q <= cw_wdata;
    end

    always @(posedge mclk) begin
        if (reset)
            cw_rdata <= 16'h0000;
        else if (ce)
            cw_rdata <= cw_hit ? cw_q : 16'h0000;
    end

    always @(posedge mclk) begin
        if (reset) begin
            submode_q <= `TYPE_POS;
            direction_q <= 1'b0;
        end else if (ce) begin
            submode_q <= sub;
            if (go)
                direction_q <= tv_neg;
        end
    end

    // Halt reporting overrides the feedback comparison
    always @(posedge mclk) begin
        if (reset) begin
            speed_zero_q <= 1'b1;
            target_reached_q <= 1'b0;
        end else if (ce) begin
            speed_zero_q <= ramp_zero;
            if (halt)
                target_reached_q <= ramp_zero;
            else
                target_reached_q <= feedback_at_target;
        end
    end

    always @(posedge mclk) begin
        if (reset) begin
            pressing_q <= 1'b0;
            deviation_hold_q <= {W{1'b0}};
        end else if (ce) begin
            pressing_q <= push_mode && load_contact && running;
            deviation_hold_q <= (push_mode && load_contact) ? PUSH_DEV : {W{1'b0}};
        end
    end

    // Overload needs the torque limit held for a while, not one glitchy sample
    always @(posedge mclk) begin
        if (reset)
            ovl_cnt_q <= 16'h0000;
        else if (ce) begin
            if (torque_at_limit && running && !push_mode) begin
                if (!ovl_full)
                    ovl_cnt_q <= ovl_cnt_q + 16'h0001;
            end else
                ovl_cnt_q <= 16'h0000;
        end
    end

    // Sticky alarms; a new fault beats a fault reset in the same cycle so none is lost
    always @(posedge mclk) begin
        if (reset) begin
            overload_alarm_q <= 1'b0;
            deviation_alarm_q <= 1'b0;
        end else if (ce) begin
            if (ovl_set)
                overload_alarm_q <= 1'b1;
            else if (fault_clear)
                overload_alarm_q <= 1'b0;
            if (dev_set)
                deviation_alarm_q <= 1'b1;
            else if (fault_clear)
                deviation_alarm_q <= 1'b0;
        end
    end

    // Position submode adds the deviation to the command so lost steps are recovered fast;
    // this is what overspeeds when a heavy load suddenly lets go
    always @(posedge mclk) begin
        if (reset)
            command_speed <= {W{1'b0}};
        else if (ce) begin
            if (pos_mode && running)
                command_speed <= ramp_speed + position_deviation;
            else
                command_speed <= ramp_speed;
        end
    end
endmodule // pv_control

// [verif/pv_checks_assertions.sv]
// Checker: pv_control outputs tied to their causes at the ports.
// Assumes the W = 32 build; bound after the module.
`timescale 1ns/1ps
module pv_checks #(
    parameter [31:0] PUSH_DEV = 32'h0000_003C
) (
    input wire mclk,
    input wire reset,
    input wire ce,
    input wire cw_we,
    input wire [15:0] cw_addr,
    input wire [15:0] cw_wdata,
    input wire [15:0] cw_rdata,
    input wire [1:0] submode_q,
    input wire [31:0] deviation_hold_q,
    input wire overload_alarm_q,
    input wire deviation_alarm_q,
    input wire torque_at_limit,
    input wire [31:0] position_deviation,
    input wire load_contact
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    wire wr = ce && cw_we && cw_addr == 16'h6040;
    mode_take_a: assert property (wr ##1 (ce && !cw_we) |=> submode_q == $past(cw_wdata[13:12], 2))
        else $error("submode not taken");
    read_other_a: assert property (ce && cw_addr != 16'h6040 |=> cw_rdata == 16'h0000)
        else $error("other address read nonzero");
    push_hold_a: assert property (ce && submode_q[1] && load_contact ##1 submode_q[1] |-> deviation_hold_q == PUSH_DEV)
        else $error("push deviation wrong");
    free_hold_a: assert property (ce && !load_contact |=> deviation_hold_q == 32'h0000_0000)
        else $error("deviation held without load");
    push_quiet_a: assert property (submode_q[1] ##1 submode_q[1] |-> !$rose(overload_alarm_q))
        else $error("alarm while pressing");
    dev_pos_a: assert property (submode_q != 2'h0 ##1 submode_q != 2'h0 |-> !$rose(deviation_alarm_q))
        else $error("deviation alarm outside position mode");
    ovl_cause_a: assert property ($rose(overload_alarm_q) |-> $past(torque_at_limit, 2))
        else $error("overload without torque limit");
    fault_clear_a: assert property (wr && cw_wdata[7] && !$past(torque_at_limit) &&
        position_deviation <= 32'h0000_0FA0 |=> !overload_alarm_q && !deviation_alarm_q)
        else $error("alarms not cleared");
    cover property (wr && cw_wdata[8]);
    cover property (submode_q == 2'h3);
    cover property ($rose(deviation_alarm_q));
endmodule // pv_checks
bind pv_control pv_checks #(.PUSH_DEV(PUSH_DEV)) chk_i (.mclk(mclk), .reset(reset), .ce(ce), .cw_we(cw_we),
    .cw_addr(cw_addr), .cw_wdata(cw_wdata), .cw_rdata(cw_rdata), .submode_q(submode_q), .load_contact(load_contact),
    .deviation_hold_q(deviation_hold_q), .overload_alarm_q(overload_alarm_q), .deviation_alarm_q(deviation_alarm_q),
    .torque_at_limit(torque_at_limit), .position_deviation(position_deviation));

// [verif/pv_master.sv]
// Partner: network master issuing control words on request.
// Assumes requests come from the bench on mclk.
`timescale 1ns/1ps
module pv_master (
    input wire mclk,
    input wire req,
    input wire [15:0] addr,
    input wire [15:0] word,
    output reg cw_we = 1'h0,
    output reg [15:0] cw_addr = 16'h6040,
    output reg [15:0] cw_wdata = 16'h0000
);
    // Idle data is the inverse of the previous cycle's data, so stale data never looks valid
    always @(posedge mclk) begin
        cw_we <= req;
        cw_addr <= addr;
        cw_wdata <= req ? word : ~cw_wdata; // no position or current objects are sent
    end
endmodule // pv_master

// [verif/tb_top.sv]
// Bench: random targets per submode, then pressing and alarm corners.
// Assumes 250 MHz mclk and synchronous reset.
`timescale 1ns/1ps
module tb_top;
    reg mclk = 1'h0, reset = 1'h1, req = 1'h0, tick = 1'h0, load = 1'h0, trq = 1'h0, en = 1'h1, fb = 1'h0;
    reg [15:0] addr = 16'h6040, word = 16'h0000;
    reg [31:0] tgt = 32'h0000_0000, acc = 32'h0000_0001, dev = 32'h0000_0000, seed = 32'h5335_6de3, e;
    reg [2:0] hopt = 3'h1;
    wire we, ovl, dal, tr, dir, prs, sz;
    wire [1:0] sm;
    wire [15:0] ca, cd, rd;
    wire [31:0] spd, dh;
    integer fails = 0, checked = 0, i;
    pv_master mst (.mclk(mclk), .req(req), .addr(addr), .word(word), .cw_we(we), .cw_addr(ca), .cw_wdata(cd));
    // Huge decel step so a halt lands on zero within one tick
    pv_control uut (.mclk(mclk), .reset(reset), .ce(en), .cw_we(we), .cw_addr(ca), .cw_wdata(cd), .cw_rdata(rd),
        .target_velocity(tgt), .accel_step(acc), .decel_step(32'h0100_0000), .halt_option(hopt), .ramp_tick(tick),
        .position_deviation(dev), .torque_at_limit(trq), .load_contact(load), .feedback_at_target(fb),
        .command_speed(spd), .direction_q(dir), .submode_q(sm), .pressing_q(prs), .deviation_hold_q(dh),
        .overload_alarm_q(ovl), .deviation_alarm_q(dal), .target_reached_q(tr), .speed_zero_q(sz));
    initial forever #2 mclk = ~mclk;
    function [31:0] rnd(input [31:0] s);
        begin
            rnd = s ^ (s << 13);
            rnd = rnd ^ (rnd >> 17);
            rnd = rnd ^ (rnd << 5);
        end
    endfunction
    function [31:0] exp_spd(input [1:0] m, input [31:0] t, input [31:0] a, input [31:0] d);
        begin
            if (m == 2'h3)
                exp_spd = t;
            else if (m == 2'h0)
                exp_spd = 32'h0000_1388 + a + d;
            else
                exp_spd = 32'h0000_1388 + a;
        end
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task test_done;
        begin
            $display("fails=%0d checked=%0d", fails, checked);
            if (fails == 0 && checked > 0) $display("verification passed");
            else $display("verification failed");
            $finish;
        end
    endtask
    task run(input integer n);
        begin
            repeat (n) @(posedge mclk);
            #1;
        end
    endtask
    task wr(input [15:0] w);
        begin
            @(posedge mclk);
            word <= w;
            req <= 1'h1;
            @(posedge mclk);
            req <= 1'h0;
            run(3);
        end
    endtask
    task pulse;
        begin
            @(posedge mclk);
            tick <= 1'h1;
            @(posedge mclk);
            tick <= 1'h0;
            run(2);
        end
    endtask
    initial begin
        repeat (16) @(posedge mclk);
        reset <= 1'h0;
        for (i = 0; i < 8; i = i + 1) begin
            seed = rnd(seed);
            @(posedge mclk);
            tgt <= 32'h0001_0000 + seed[15:0];
            acc <= seed[23:16] + 8'h01;
            dev <= seed[26:16];
            hopt <= seed[31] ? 3'h2 : 3'h1;
            wr(16'h0100);
            if (i > 0) chk(tr, 1'h0);
            pulse;
            pulse;
            chk(tr, 1'h1);
            chk(sz, 1'h1);
            wr({2'h0, i[1:0], 12'h000});
            chk(sm, i[1:0]);
            e = exp_spd(i[1:0], tgt, acc, dev);
            pulse;
            chk(spd, e);
            chk(dir, 1'h0);
            chk(sz, 1'h0);
            chk(prs, 1'h0);
        end
        chk(rd, 16'h3000);
        @(posedge mclk);
        addr <= 16'h6041;
        run(3);
        chk(rd, 16'h0000);
        @(posedge mclk);
        addr <= 16'h6040;
        load <= 1'h1;
        trq <= 1'h1;
        wr(16'h2000);
        run(250);
        chk(dh, 32'h0000_003C);
        chk(ovl, 1'h0);
        chk(prs, 1'h1);
        wr(16'h1000);
        run(250);
        chk({ovl, dal}, 2'h2);
        @(posedge mclk);
        trq <= 1'h0;
        wr(16'h1080);
        chk({ovl, dal}, 2'h0);
        @(posedge mclk);
        dev <= 32'h0000_1000;
        wr(16'h0000);
        run(50);
        chk(dal, 1'h1);
        @(posedge mclk);
        tgt <= 32'hFFFE_0000;
        wr(16'h0100);
        pulse;
        pulse;
        chk(tr, 1'h1);
        wr(16'h1000);
        chk(dir, 1'h1);
        chk(spd, 32'hFFFF_EC78);
        // Clock enable low: a tick must not move the ramp
        @(posedge mclk);
        en <= 1'h0;
        pulse;
        chk(spd, 32'hFFFF_EC78);
        @(posedge mclk);
        en <= 1'h1;
        pulse;
        chk(spd, 32'hFFFF_EC78 - acc);
        chk(tr, 1'h0);
        @(posedge mclk);
        fb <= 1'h1;
        run(2);
        chk(tr, 1'h1);
        test_done;
    end
    initial begin
        #100000;
        fails = fails + 1;
        test_done;
    end
endmodule // tb_top
